// [core/cmfs_clkdiv.sv]
// cmfs_clkdiv: module clock enable generator
// assumes the fast clock is twice the peripheral rate
`timescale 1ns/1ps
module cmfs_clkdiv (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic run,
   input  wire logic double_rate,
   output logic      tick
);
   logic phase;

   // double rate ticks every cycle, single rate every other cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 1'b0;
         tick  <= 1'b0;
      end else if (ce) begin
         phase <= run ? ~phase : 1'b0;
         tick  <= run && (double_rate || phase);
      end
   end
endmodule : cmfs_clkdiv

// [core/cmfs_core.sv]
// cmfs_core: can mode control, abort, capture and fifo pointer status
// assumes axi4-lite master on aclk; can engine events arrive on aclk
`timescale 1ns/1ps
module cmfs_core #(
   parameter int NUM_TX = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   input  wire logic [3:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [3:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              device_idle,
   input  wire logic              msg_received,
   input  wire logic              buffer_advance,
   input  wire logic              buffer_read_done,
   input  wire logic [NUM_TX-1:0] tx_pending,
   output logic [NUM_TX-1:0]      tx_abort,
   output logic                   capture_event,
   output logic                   filter_window,
   output logic                   module_clock_tick,
   output logic [2:0]             mode_out
);
   typedef enum logic [1:0] {CMFS_ST_STEADY, CMFS_ST_SETTLE} cmfs_state_e;

   logic        stop_in_idle;
   logic        abort_all_transmit;
   logic        module_clock_select;
   logic [2:0]  mode_request;
   logic [2:0]  mode_status;
   logic        receive_capture_enable;
   logic        register_map_window_select;
   logic [5:0]  fifo_buffer_pointer;
   logic [5:0]  fifo_next_read_pointer;
   logic        idle_sync1, idle_sync2;
   logic        halted;
   cmfs_state_e state;
   logic [7:0]  settle_cnt;
   logic        aw_held, w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;
   logic [15:0] ctrl_word;
   logic [15:0] fifo_word;
   logic        tick;

   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign ctrl_word = {2'h0, stop_in_idle, abort_all_transmit, module_clock_select,
                       mode_request, mode_status, 1'b0, receive_capture_enable,
                       2'h0, register_map_window_select};
   assign fifo_word = {2'h0, fifo_buffer_pointer, 2'h0, fifo_next_read_pointer};

   // idle arrives from the power manager, another domain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_sync1 <= 1'b0;
         idle_sync2 <= 1'b0;
      end else if (ce) begin
         idle_sync1 <= device_idle;
         idle_sync2 <= idle_sync1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) halted <= 1'b0;
      else if (ce) halted <= stop_in_idle && idle_sync2;
   end

   // write address and data channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= cmfs_pkg::CMFS_RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == cmfs_pkg::CMFS_OFF_CTRL ||
                             aw_addr == cmfs_pkg::CMFS_OFF_FIFO ||
                             aw_addr == cmfs_pkg::CMFS_OFF_PEND) ?
                            cmfs_pkg::CMFS_RESP_OKAY : cmfs_pkg::CMFS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // control fields; fifo and pending registers ignore writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_in_idle               <= 1'b0;
         module_clock_select        <= 1'b0;
         mode_request               <= cmfs_pkg::CMFS_MODE_CONFIG;
         receive_capture_enable     <= 1'b0;
         register_map_window_select <= 1'b0;
      end else if (ce && wr_go && aw_addr == cmfs_pkg::CMFS_OFF_CTRL) begin
         if (w_strb[1]) begin
            stop_in_idle        <= w_data[cmfs_pkg::CMFS_BIT_IDLE];
            module_clock_select <= w_data[cmfs_pkg::CMFS_BIT_CKS];
            // reserved codes are held off; the old request stands
            if (w_data[cmfs_pkg::CMFS_REQ_LSB +: 3] != cmfs_pkg::CMFS_MODE_RSV5 &&
                w_data[cmfs_pkg::CMFS_REQ_LSB +: 3] != cmfs_pkg::CMFS_MODE_RSV6)
               mode_request <= w_data[cmfs_pkg::CMFS_REQ_LSB +: 3];
         end
         if (w_strb[0]) begin
            receive_capture_enable     <= w_data[cmfs_pkg::CMFS_BIT_CAP];
            register_map_window_select <= w_data[cmfs_pkg::CMFS_BIT_WIN];
         end
      end
   end

   // abort: software sets, hardware clears when nothing is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) abort_all_transmit <= 1'b0;
      else if (ce) begin
         if (wr_go && aw_addr == cmfs_pkg::CMFS_OFF_CTRL && w_strb[1] &&
             w_data[cmfs_pkg::CMFS_BIT_ABORT])
            abort_all_transmit <= 1'b1;
         else if (abort_all_transmit && tx_pending == '0)
            abort_all_transmit <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) tx_abort <= '0;
      else if (ce) tx_abort <= abort_all_transmit ? tx_pending : '0;
   end

   // mode changes take a short settle time before status follows
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state       <= CMFS_ST_STEADY;
         settle_cnt  <= 8'h0;
         mode_status <= cmfs_pkg::CMFS_MODE_CONFIG;
      end else if (ce && !halted) begin
         unique case (state)
            CMFS_ST_STEADY: begin
               if (mode_request != mode_status) begin
                  state      <= CMFS_ST_SETTLE;
                  settle_cnt <= 8'(cmfs_pkg::CMFS_MODE_SETTLE_CYC - 1);
               end
            end
            CMFS_ST_SETTLE: begin
               if (settle_cnt == 8'h0) begin
                  mode_status <= mode_request;
                  state       <= CMFS_ST_STEADY;
               end else begin
                  settle_cnt <= settle_cnt - 8'h1;
               end
            end
         endcase
      end
   end

   // fifo pointers wrap inside the 32 buffers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fifo_buffer_pointer    <= cmfs_pkg::CMFS_PTR_RESET;
         fifo_next_read_pointer <= cmfs_pkg::CMFS_PTR_RESET;
      end else if (ce && !halted) begin
         if (buffer_advance)
            fifo_buffer_pointer <= (fifo_buffer_pointer == cmfs_pkg::CMFS_PTR_LAST) ?
               cmfs_pkg::CMFS_PTR_RESET : fifo_buffer_pointer + 6'h1;
         if (buffer_read_done)
            fifo_next_read_pointer <= (fifo_next_read_pointer == cmfs_pkg::CMFS_PTR_LAST) ?
               cmfs_pkg::CMFS_PTR_RESET : fifo_next_read_pointer + 6'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_event     <= 1'b0;
         filter_window     <= 1'b0;
         mode_out          <= cmfs_pkg::CMFS_MODE_CONFIG;
         module_clock_tick <= 1'b0;
      end else if (ce) begin
         capture_event     <= receive_capture_enable && msg_received && !halted;
         filter_window     <= register_map_window_select;
         mode_out          <= mode_status;
         module_clock_tick <= tick;
      end
   end

   // read channel, one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= cmfs_pkg::CMFS_RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cmfs_pkg::CMFS_RESP_OKAY;
            unique case (s_axi_araddr)
               cmfs_pkg::CMFS_OFF_CTRL: s_axi_rdata <= {16'h0, ctrl_word};
               cmfs_pkg::CMFS_OFF_FIFO: s_axi_rdata <= {16'h0, fifo_word};
               cmfs_pkg::CMFS_OFF_PEND: s_axi_rdata <= 32'(tx_pending);
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= cmfs_pkg::CMFS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   cmfs_clkdiv u_clkdiv (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .run         (!halted),
      .double_rate (module_clock_select),
      .tick        (tick)
   );

   property p_abort_clears;
      @(posedge aclk) disable iff (!aresetn)
      (ce && abort_all_transmit && tx_pending == '0 && !wr_go) |=> !abort_all_transmit;
   endproperty
   a_abort_clears: assert property (p_abort_clears)
      else $error("abort bit not cleared");

   property p_capture_gated;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !receive_capture_enable) |=> !capture_event;
   endproperty
   a_capture_gated: assert property (p_capture_gated)
      else $error("capture event while disabled");

   property p_status_legal;
      @(posedge aclk) disable iff (!aresetn)
      mode_status != cmfs_pkg::CMFS_MODE_RSV5 && mode_status != cmfs_pkg::CMFS_MODE_RSV6;
   endproperty
   a_status_legal: assert property (p_status_legal)
      else $error("mode status reserved");

   property p_halt_idle;
      @(posedge aclk) disable iff (!aresetn)
      (ce && halted) |=> $stable(fifo_buffer_pointer) && !capture_event;
   endproperty
   a_halt_idle: assert property (p_halt_idle)
      else $error("activity while halted");

   property p_window;
      @(posedge aclk) disable iff (!aresetn)
      ce |=> filter_window == $past(register_map_window_select);
   endproperty
   a_window: assert property (p_window)
      else $error("window output wrong");

   // a pointer past buffer 31 would index a buffer that does not exist
   property p_ptr_range;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !halted && buffer_advance && fifo_buffer_pointer == cmfs_pkg::CMFS_PTR_LAST)
      |=> fifo_buffer_pointer == cmfs_pkg::CMFS_PTR_RESET;
   endproperty
   a_ptr_range: assert property (p_ptr_range)
      else $error("fifo pointer did not wrap");

   property p_mode_follow;
      @(posedge aclk) disable iff (!aresetn)
      (ce && !halted && state == CMFS_ST_STEADY && mode_request != mode_status)
      ##1 (ce && !halted)[*4] |=> mode_status == $past(mode_request);
   endproperty
   a_mode_follow: assert property (p_mode_follow)
      else $error("mode status not following");

   property p_double_tick;
      @(posedge aclk) disable iff (!aresetn)
      (ce && module_clock_select && !halted)[*2] |=> tick;
   endproperty
   a_double_tick: assert property (p_double_tick)
      else $error("double rate tick missing");
endmodule : cmfs_core

// [inc/cmfs_pkg.sv]
// cmfs_pkg: constants for the can mode and fifo status block
// assumes a 32-bit axi4-lite register bus, one clock
// Summary of operation
// - stop_in_idle halts controller during device idle
// - abort_all_transmit aborts all, hardware clears after
// - module_clock_select one doubles module clock rate
// - mode_request codes; 101 and 110 reserved
// - mode_status reports actual mode, same encoding
// - receive_capture_enable gates capture event per receive
// - window select: one filters, zero buffers
// - fifo_buffer_pointer gives current buffer index 0-31
// - fifo_next_read_pointer gives next buffer to read
package cmfs_pkg;
   localparam logic [3:0] CMFS_OFF_CTRL   = 4'h0;
   localparam logic [3:0] CMFS_OFF_FIFO   = 4'h4;
   localparam logic [3:0] CMFS_OFF_PEND   = 4'h8;
   localparam int CMFS_BIT_IDLE           = 13;
   localparam int CMFS_BIT_ABORT          = 12;
   localparam int CMFS_BIT_CKS            = 11;
   localparam int CMFS_REQ_LSB            = 8;
   localparam int CMFS_STAT_LSB           = 5;
   localparam int CMFS_BIT_CAP            = 3;
   localparam int CMFS_BIT_WIN            = 0;
   localparam int CMFS_FBP_LSB            = 8;
   localparam int CMFS_FIFO_NEXT_READ_POINTER_LSB           = 0;
   localparam logic [2:0] CMFS_MODE_NORMAL = 3'h0;
   localparam logic [2:0] CMFS_MODE_DIS    = 3'h1;
   localparam logic [2:0] CMFS_MODE_LOOP   = 3'h2;
   localparam logic [2:0] CMFS_MODE_LISTEN = 3'h3;
   localparam logic [2:0] CMFS_MODE_CONFIG = 3'h4;
   localparam logic [2:0] CMFS_MODE_RSV5   = 3'h5;
   localparam logic [2:0] CMFS_MODE_RSV6   = 3'h6;
   localparam logic [2:0] CMFS_MODE_ALL    = 3'h7;
   localparam logic [5:0] CMFS_PTR_RESET   = 6'h00;
   localparam logic [5:0] CMFS_PTR_LAST    = 6'h1f;
   localparam logic [1:0] CMFS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CMFS_RESP_SLVERR = 2'h2;
   localparam int CMFS_CLK_MHZ            = 40;
   localparam int CMFS_MODE_SETTLE_NS     = 100;
   localparam int CMFS_MODE_SETTLE_CYC    =
      (CMFS_MODE_SETTLE_NS * CMFS_CLK_MHZ + 999) / 1000;
endpackage : cmfs_pkg

// [testbench/cmfs_can_model.sv]
// cmfs_can_model: can engine stand-in feeding events to the core
// assumes the bench calls its tasks from the aclk domain
`timescale 1ns/1ps
module cmfs_can_model #(
   parameter int ABORT_DELAY = 3
) (
   input  wire logic       aclk,
   input  wire logic [7:0] tx_abort,
   output logic [7:0]      tx_pending,
   output logic            msg_received,
   output logic            buffer_advance,
   output logic            buffer_read_done,
   output logic            device_idle
);
   int wait_cnt = 0;
   initial begin
      tx_pending = 8'h00;
      msg_received = 1'b0;
      buffer_advance = 1'b0;
      buffer_read_done = 1'b0;
      device_idle = 1'b0;
   end
   // slow on purpose: pending drops some cycles after abort
   always @(posedge aclk) begin
      if ((tx_abort & tx_pending) == 8'h00) begin
         wait_cnt <= 0;
      end else if (wait_cnt < ABORT_DELAY) begin
         wait_cnt <= wait_cnt + 1;
      end else begin
         tx_pending <= tx_pending & ~tx_abort;
      end
   end
   task automatic pulse(input int kind, input int n);
      repeat (n) begin
         @(posedge aclk);
         msg_received <= (kind == 0);
         buffer_advance <= (kind == 1);
         buffer_read_done <= (kind == 2);
         @(posedge aclk);
         msg_received <= 1'b0;
         buffer_advance <= 1'b0;
         buffer_read_done <= 1'b0;
      end
   endtask : pulse
   task automatic load_pending(input logic [7:0] v);
      @(posedge aclk);
      tx_pending <= v;
   endtask : load_pending
   task automatic set_idle(input logic v);
      @(posedge aclk);
      device_idle <= v;
   endtask : set_idle
endmodule : cmfs_can_model

// [testbench/tb_cmfs_core.sv]
// tb_cmfs_core: register-level bench for the can mode and fifo status core
// assumes cmfs_can_model stands in for the can engine
`timescale 1ns/1ps
module tb_cmfs_core;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, capture_event, filter_window, tick;
   logic        msg_received, buffer_advance, buffer_read_done, device_idle, ce;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rdat;
   logic [1:0]  bresp, rresp, resp;
   logic [7:0]  tx_pending, tx_abort, abort_seen;
   logic [2:0]  mode_out;
   logic [2:0]  modes [6] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h0};
   int          miscompares, cmp_count, ticks, caps;

   cmfs_core DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .device_idle(device_idle),
      .msg_received(msg_received), .buffer_advance(buffer_advance),
      .buffer_read_done(buffer_read_done), .tx_pending(tx_pending),
      .tx_abort(tx_abort), .capture_event(capture_event),
      .filter_window(filter_window), .module_clock_tick(tick), .mode_out(mode_out));
   cmfs_can_model model (.aclk(aclk), .tx_abort(tx_abort), .tx_pending(tx_pending),
      .msg_received(msg_received), .buffer_advance(buffer_advance),
      .buffer_read_done(buffer_read_done), .device_idle(device_idle));

   // counted on the falling edge so the bench never races the core
   always @(negedge aclk) begin
      if (tick === 1'b1) ticks++;
      if (capture_event === 1'b1) caps++;
      abort_seen |= tx_abort;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      logic aw;
      logic w;
      n = 0;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w) && n < 100) begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         aw = aw | (awready === 1'b1);
         w = w | (wready === 1'b1);
      end
      while (bvalid !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      resp = bresp;
      bready <= 1'b0;
      if (n >= 100) miscompares++;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (arready !== 1'b1 && n < 100);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      rdat = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 100) miscompares++;
   endtask : rd
   // f = {stop_in_idle, abort, clock select, capture enable, window}
   function automatic logic [31:0] cw(input logic [2:0] req, input logic [4:0] f);
      return {18'h0, f[4:2], req, 4'h0, f[1], 2'h0, f[0]};
   endfunction : cw

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // tests need about 500 cycles; 4000 cycles means something hangs
   initial begin
      #100000;
      miscompares++;
      report_and_stop;
   end
   initial begin
      int t0;
      int k;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      ce = 1'b1;
      wstrb = 4'hf;
      {miscompares, cmp_count, ticks, caps} = '0;
      abort_seen = 8'h00;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(cmfs_pkg::CMFS_OFF_CTRL);
      chk(rdat, 32'h0000_0480);
      chk(32'(mode_out), 32'h4);
      rd(cmfs_pkg::CMFS_OFF_FIFO);
      chk(rdat, 32'h0);
      $display("test reset done");
      foreach (modes[i]) begin
         wr(cmfs_pkg::CMFS_OFF_CTRL, cw(modes[i], 5'h00));
         k = 0;
         do begin
            rd(cmfs_pkg::CMFS_OFF_CTRL);
            k++;
         end while (rdat[7:5] !== modes[i] && k < 20);
         chk(32'(rdat[10:5]), 32'({modes[i], modes[i]}));
         chk(32'(mode_out), 32'(modes[i]));
      end
      for (int r = 5; r < 7; r++) begin
         wr(cmfs_pkg::CMFS_OFF_CTRL, cw(3'(r), 5'h00));
         rd(cmfs_pkg::CMFS_OFF_CTRL);
         chk(32'(rdat[10:5]), 32'h0);
      end
      $display("test modes done");
      for (int c = 0; c < 5; c++) begin
         wr(cmfs_pkg::CMFS_OFF_CTRL, cw(3'h0, {c == 1 || c == 4, 1'b0, c != 0, 2'b00}));
         model.set_idle(c > 2);
         repeat (6) @(posedge aclk);
         t0 = ticks;
         repeat (8) @(posedge aclk);
         chk(32'(ticks - t0), (c == 4) ? 32'h0 : (c == 0) ? 32'h4 : 32'h8);
      end
      model.set_idle(1'b0);
      $display("test clock and idle done");
      for (int e = 0; e < 2; e++) begin
         wr(cmfs_pkg::CMFS_OFF_CTRL, cw(3'h0, {3'b001, 1'(e), 1'(e)}));
         t0 = caps;
         model.pulse(0, 1);
         repeat (3) @(posedge aclk);
         chk(32'(caps - t0), 32'(e));
         chk(32'(filter_window), 32'(e));
      end
      $display("test capture and window done");
      model.load_pending(8'h0f);
      rd(cmfs_pkg::CMFS_OFF_PEND);
      chk(rdat, 32'h0f);
      abort_seen = 8'h00;
      wr(cmfs_pkg::CMFS_OFF_CTRL, cw(3'h0, 5'b01010));
      k = 0;
      do begin
         rd(cmfs_pkg::CMFS_OFF_CTRL);
         k++;
      end while (rdat[12] !== 1'b0 && k < 20);
      chk(32'(rdat[12]), 32'h0);
      chk(32'(abort_seen), 32'h0f);
      chk(32'(tx_pending), 32'h0);
      $display("test abort done");
      model.pulse(1, 33);
      model.pulse(2, 31);
      // pulses while ce is low must leave the pointers where they are
      ce <= 1'b0;
      model.pulse(1, 4);
      ce <= 1'b1;
      wr(cmfs_pkg::CMFS_OFF_FIFO, 32'hffff_ffff);
      chk(32'(resp), 32'(cmfs_pkg::CMFS_RESP_OKAY));
      rd(cmfs_pkg::CMFS_OFF_FIFO);
      chk(rdat, 32'h0000_011f);
      rd(4'hc);
      chk(rdat, 32'h0);
      chk(32'(resp), 32'(cmfs_pkg::CMFS_RESP_SLVERR));
      // low byte lane only: request and upper control bits keep their values
      wstrb <= 4'h1;
      wr(cmfs_pkg::CMFS_OFF_CTRL, cw(3'h2, 5'h11));
      wstrb <= 4'hf;
      rd(cmfs_pkg::CMFS_OFF_CTRL);
      chk(rdat, 32'h0000_0001);
      $display("test fifo and map done");
      report_and_stop;
   end
endmodule : tb_cmfs_core
